// >>> docd_pkg.sv
// constants, types and register map of the dual output clock divider
// Notes on behaviour
// RL1 - reference prescaler divides master by 1/2/4/8
// RL2 - main prescaler feeds main output or divider
// RL3 - main divider ratio ranges 2 through 1025
// RL4 - bypass bit sends main prescaler straight out
// RL5 - divider value lives in its own register
// RL6 - undivided master clock selectable on either output
// RL7 - settings restored from nonvolatile store at power-up
// RL8 - host writes settings; store keeps them
// RL9 - reference output driven from source multiplexer
// RL10 - pin a: select, enable or power-down
// RL11 - pin b: main enable or power-down
// RL12 - reference unused, pin a shuts device down
// RL13 - divider ratio equals programmed value plus two
// RL14 - prescale codes 00/01/10/11 give 1/2/4/8
// RL15 - outputs float only after reaching low level
// RL16 - outputs disabled until oscillator start-up elapses
// RL17 - setting changes applied at period boundaries only
// RL18 - control pins synchronised before any use
package docd_pkg;

  // ******************************************************************
  // register bus and map
  // ******************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0]  REG_MUX  = 4'h0;
  localparam logic [3:0]  REG_DIV  = 4'h1;
  localparam logic [3:0]  REG_STAT = 4'h2;

  // mode word fields
  localparam int unsigned BIT_BYPASS   = 0;
  localparam int unsigned BIT_MAIN_LO  = 1;
  localparam int unsigned BIT_MAIN_HI  = 2;
  localparam int unsigned BIT_REF_LO   = 3;
  localparam int unsigned BIT_REF_HI   = 4;
  localparam int unsigned BIT_REF_EN   = 5;
  localparam int unsigned BIT_REF_SRC  = 6;
  localparam int unsigned BIT_REF_PDN  = 7;
  localparam int unsigned BIT_MAIN_PDN = 8;
  localparam logic [15:0] MUX_MASK     = 16'h01ff;
  localparam logic [15:0] DIV_MASK     = 16'h03ff;

  // status word fields
  localparam int unsigned BIT_ST_READY = 0;
  localparam int unsigned BIT_ST_PDN   = 1;
  localparam int unsigned BIT_ST_REF   = 2;
  localparam int unsigned BIT_ST_MAIN  = 3;

  // factory contents of the nonvolatile store
  localparam logic [15:0] MUX_RST = 16'h0060;
  localparam logic [15:0] DIV_RST = 16'h0000;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned STARTUP_OSC_CYCLES = 8000;
  localparam int unsigned CLK_PER_OSC        = 2;
  localparam int unsigned STARTUP_W          = 16;
  localparam int unsigned HALF_W             = 14;
  localparam logic [13:0] DIV_OFFSET         = 14'h0002;
  localparam logic [13:0] HALF_RST           = 14'h0001;

  typedef enum logic [1:0] {
    MODE_STARTUP   = 2'b00,
    MODE_ACTIVE    = 2'b01,
    MODE_POWERDOWN = 2'b10
  } docd_mode_e;

  typedef struct packed {
    logic        level;
    logic        drv;
    logic [13:0] cnt;
    logic [13:0] half;
  } docd_gen_s;

endpackage

// >>> docd_top.sv
// dual output clock divider: configuration, control pins, two generators
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
module docd_top #(
  parameter int unsigned STARTUP_CLKS =
    docd_pkg::STARTUP_OSC_CYCLES * docd_pkg::CLK_PER_OSC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        control_pin_a,
  input  wire logic        control_pin_b,
  output logic             reference_clock_out,
  output logic             reference_clock_out_oe_n,
  output logic             main_clock_out,
  output logic             main_clock_out_oe_n
);

  // ******************************************************************
  // helpers
  // ******************************************************************
  localparam logic [15:0] START_LAST = 16'(STARTUP_CLKS - 1);

  function automatic logic [13:0] presc_div(input logic [1:0] code);
    logic [13:0] m;
    m = 14'h0001;
    case (code)
      2'b00:   m = 14'h0001; // [RL14]
      2'b01:   m = 14'h0002; // [RL14]
      2'b10:   m = 14'h0004; // [RL14]
      2'b11:   m = 14'h0008; // [RL14]
      default: m = 14'h0001;
    endcase
    return m;
  endfunction

  // one clk cycle, half a master cycle, per step; new half taken only at a rising edge
  function automatic docd_pkg::docd_gen_s gen_step(
    input docd_pkg::docd_gen_s cur,
    input logic [13:0]         half_new,
    input logic                en_req
  );
    docd_pkg::docd_gen_s nx;
    nx = cur;
    if (cur.cnt <= 14'h0001) begin
      nx.level = ~cur.level;
      if (!cur.level) begin
        nx.half = half_new; // [RL17]
        nx.cnt  = half_new;
      end else begin
        nx.cnt = cur.half;
      end
    end else begin
      nx.cnt = cur.cnt - 14'h0001;
    end
    // float only after a driven low cycle, enable only into a low one
    if (en_req ? !nx.level : !cur.level) begin
      nx.drv = en_req; // [RL15]
    end
    return nx;
  endfunction

  // ******************************************************************
  // declarations
  // ******************************************************************
  logic [15:0] nv_mem [2] = '{docd_pkg::MUX_RST, docd_pkg::DIV_RST};

  logic [15:0]          mux_ff;
  logic [15:0]          nxt_mux;
  logic [15:0]          div_ff;
  logic [15:0]          nxt_div;
  logic [15:0]          rdata_ff;
  logic [15:0]          nxt_rdata;
  logic                 cfg_we;
  logic [2:0]           sync_a_ff;
  logic [2:0]           nxt_sync_a;
  logic [2:0]           sync_b_ff;
  logic [2:0]           nxt_sync_b;
  logic                 pin_a_ff;
  logic                 nxt_pin_a;
  logic                 pin_b_ff;
  logic                 nxt_pin_b;
  docd_pkg::docd_mode_e mode_ff;
  docd_pkg::docd_mode_e nxt_mode;
  logic [15:0]          start_cnt_ff;
  logic [15:0]          nxt_start_cnt;
  docd_pkg::docd_gen_s  ref_gen_ff;
  docd_pkg::docd_gen_s  nxt_ref_gen;
  docd_pkg::docd_gen_s  main_gen_ff;
  docd_pkg::docd_gen_s  nxt_main_gen;
  logic                 ref_out_ff;
  logic                 ref_oe_n_ff;
  logic                 main_out_ff;
  logic                 main_oe_n_ff;
  logic                 shutdown;
  logic                 ref_use_presc;
  logic                 ref_en;
  logic                 main_en;
  logic [13:0]          ref_half;
  logic [13:0]          main_half;
  logic                 bypass;
  logic                 ref_en_sel;
  logic                 ref_src_sel;
  logic                 ref_pdn_sel;
  logic                 main_pdn_sel;

  // ******************************************************************
  // configuration registers and bus
  // ******************************************************************
  always_comb begin
    // programming is locked out while powered down
    cfg_we  = reg_wr && (mode_ff != docd_pkg::MODE_POWERDOWN); // [RL8]
    nxt_mux = mux_ff;
    nxt_div = div_ff;
    if (cfg_we && reg_addr == docd_pkg::REG_MUX) begin
      nxt_mux = reg_wdata & docd_pkg::MUX_MASK;
    end
    if (cfg_we && reg_addr == docd_pkg::REG_DIV) begin
      nxt_div = reg_wdata & docd_pkg::DIV_MASK; // [RL5]
    end
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        docd_pkg::REG_MUX: nxt_rdata = mux_ff;
        docd_pkg::REG_DIV: nxt_rdata = div_ff;
        docd_pkg::REG_STAT: begin
          nxt_rdata[docd_pkg::BIT_ST_READY] =
            (mode_ff == docd_pkg::MODE_ACTIVE);
          nxt_rdata[docd_pkg::BIT_ST_PDN] =
            (mode_ff == docd_pkg::MODE_POWERDOWN);
          nxt_rdata[docd_pkg::BIT_ST_REF]  = ~ref_oe_n_ff;
          nxt_rdata[docd_pkg::BIT_ST_MAIN] = ~main_oe_n_ff;
        end
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mux_ff   <= nv_mem[0]; // [RL7]
      div_ff   <= nv_mem[1]; // [RL7]
      rdata_ff <= 16'h0000;
    end else begin
      mux_ff   <= nxt_mux;
      div_ff   <= nxt_div;
      rdata_ff <= nxt_rdata;
    end
  end

  // store written through so the next power-up sees the new value
  always_ff @(posedge clk) begin
    if (!reset && cfg_we && reg_addr == docd_pkg::REG_MUX) begin
      nv_mem[0] <= reg_wdata & docd_pkg::MUX_MASK; // [RL8]
    end
    if (!reset && cfg_we && reg_addr == docd_pkg::REG_DIV) begin
      nv_mem[1] <= reg_wdata & docd_pkg::DIV_MASK; // [RL8]
    end
  end

  // ******************************************************************
  // control pin synchronisers
  // ******************************************************************
  always_comb begin
    nxt_sync_a = {sync_a_ff[1:0], control_pin_a}; // [RL18]
    nxt_sync_b = {sync_b_ff[1:0], control_pin_b}; // [RL18]
    nxt_pin_a  = pin_a_ff;
    nxt_pin_b  = pin_b_ff;
    if (sync_a_ff[1] == sync_a_ff[2]) begin
      nxt_pin_a = sync_a_ff[2]; // [RL18]
    end
    if (sync_b_ff[1] == sync_b_ff[2]) begin
      nxt_pin_b = sync_b_ff[2]; // [RL18]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a_ff <= 3'h0;
      sync_b_ff <= 3'h0;
      pin_a_ff  <= 1'b0;
      pin_b_ff  <= 1'b0;
    end else begin
      sync_a_ff <= nxt_sync_a;
      sync_b_ff <= nxt_sync_b;
      pin_a_ff  <= nxt_pin_a;
      pin_b_ff  <= nxt_pin_b;
    end
  end

  // ******************************************************************
  // pin roles and source selection
  // ******************************************************************
  always_comb begin
    bypass       = mux_ff[docd_pkg::BIT_BYPASS];
    ref_en_sel   = mux_ff[docd_pkg::BIT_REF_EN];
    ref_src_sel  = mux_ff[docd_pkg::BIT_REF_SRC];
    ref_pdn_sel  = mux_ff[docd_pkg::BIT_REF_PDN];
    main_pdn_sel = mux_ff[docd_pkg::BIT_MAIN_PDN];
    // either pin may shut the whole device down
    shutdown = (ref_pdn_sel && pin_a_ff)
             || (!ref_pdn_sel && !ref_en_sel && !ref_src_sel
                 && pin_a_ff) // [RL12]
             || (main_pdn_sel && pin_b_ff); // [RL11]
    if (ref_pdn_sel || ref_en_sel) begin
      ref_use_presc = ref_src_sel; // [RL10]
    end else begin
      ref_use_presc = pin_a_ff; // [RL10]
    end
    if (ref_pdn_sel) begin
      ref_en = 1'b1; // [RL10]
    end else if (ref_en_sel) begin
      ref_en = !pin_a_ff; // [RL10]
    end else begin
      ref_en = ref_src_sel; // [RL12]
    end
    main_en = main_pdn_sel || !pin_b_ff; // [RL11]
    // undivided master is a half period of one cycle
    ref_half = ref_use_presc ?
      presc_div(mux_ff[docd_pkg::BIT_REF_HI:docd_pkg::BIT_REF_LO]) :
      docd_pkg::HALF_RST; // [RL1] [RL6] [RL9]
    if (bypass) begin
      main_half = presc_div(
        mux_ff[docd_pkg::BIT_MAIN_HI:docd_pkg::BIT_MAIN_LO]); // [RL4]
    end else begin
      main_half = 14'(presc_div(
        mux_ff[docd_pkg::BIT_MAIN_HI:docd_pkg::BIT_MAIN_LO])
        * ({4'h0, div_ff[9:0]} + docd_pkg::DIV_OFFSET)); // [RL2] [RL3] [RL13]
    end
  end

  // ******************************************************************
  // device mode and start-up delay
  // ******************************************************************
  always_comb begin
    nxt_mode      = mode_ff;
    nxt_start_cnt = start_cnt_ff;
    case (mode_ff)
      docd_pkg::MODE_STARTUP: begin
        nxt_start_cnt = start_cnt_ff + 16'h0001;
        if (shutdown) begin
          nxt_mode = docd_pkg::MODE_POWERDOWN;
        end else if (start_cnt_ff >= START_LAST) begin
          nxt_mode = docd_pkg::MODE_ACTIVE; // [RL16]
        end
      end
      docd_pkg::MODE_ACTIVE: begin
        if (shutdown) begin
          nxt_mode = docd_pkg::MODE_POWERDOWN;
        end
      end
      docd_pkg::MODE_POWERDOWN: begin
        // oscillator restarts, so the settle time runs again
        nxt_start_cnt = 16'h0000;
        if (!shutdown) begin
          nxt_mode = docd_pkg::MODE_STARTUP; // [RL16]
        end
      end
      default: begin
        nxt_mode      = docd_pkg::MODE_STARTUP;
        nxt_start_cnt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff      <= docd_pkg::MODE_STARTUP;
      start_cnt_ff <= 16'h0000;
    end else begin
      mode_ff      <= nxt_mode;
      start_cnt_ff <= nxt_start_cnt;
    end
  end

  // ******************************************************************
  // output generators
  // ******************************************************************
  always_comb begin
    nxt_ref_gen  = gen_step(ref_gen_ff, ref_half,
      ref_en && mode_ff == docd_pkg::MODE_ACTIVE); // [RL16]
    nxt_main_gen = gen_step(main_gen_ff, main_half,
      main_en && mode_ff == docd_pkg::MODE_ACTIVE); // [RL16]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_gen_ff   <= '{1'b0, 1'b0, docd_pkg::HALF_RST, docd_pkg::HALF_RST};
      main_gen_ff  <= '{1'b0, 1'b0, docd_pkg::HALF_RST, docd_pkg::HALF_RST};
      ref_out_ff   <= 1'b0;
      ref_oe_n_ff  <= 1'b1;
      main_out_ff  <= 1'b0;
      main_oe_n_ff <= 1'b1;
    end else begin
      ref_gen_ff   <= nxt_ref_gen;
      main_gen_ff  <= nxt_main_gen;
      ref_out_ff   <= nxt_ref_gen.level && nxt_ref_gen.drv;
      ref_oe_n_ff  <= !nxt_ref_gen.drv; // [RL15]
      main_out_ff  <= nxt_main_gen.level && nxt_main_gen.drv;
      main_oe_n_ff <= !nxt_main_gen.drv; // [RL15]
    end
  end

  assign reg_rdata                = rdata_ff;
  assign reference_clock_out      = ref_out_ff;
  assign reference_clock_out_oe_n = ref_oe_n_ff;
  assign main_clock_out           = main_out_ff;
  assign main_clock_out_oe_n      = main_oe_n_ff;

endmodule // docd_top

// >>> docd_host.sv
// host model that drives the register port of the clock divider
`timescale 1ns/10ps
module docd_host (
  input  wire logic        clk,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  // ******************************
  // bus cycles
  // ******************************
  // expected read data, oldest first, popped by the bench monitor
  logic [15:0] exp_q[$];

  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // settings go out over the bus; the device keeps them
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
endmodule // docd_host

// >>> docd_top_asserts.sv
// concurrent checks on the ports of the clock divider top
`timescale 1ns/10ps
module docd_top_asserts #(
  parameter int unsigned STARTUP_CLKS = 20
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reference_clock_out,
  input wire logic        reference_clock_out_oe_n,
  input wire logic        main_clock_out,
  input wire logic        main_clock_out_oe_n
);
  // ******************************
  // properties
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // needs STARTUP_CLKS of at least 7
  startup_hold_a: assert property ($fell(reset) |->
    (reference_clock_out_oe_n && main_clock_out_oe_n)[*8])
    else $error("output driven during startup");
  ref_float_low_a: assert property (
    reference_clock_out_oe_n |-> !reference_clock_out)
    else $error("floating reference not low");
  main_float_low_a: assert property (
    main_clock_out_oe_n |-> !main_clock_out)
    else $error("floating main not low");
  ref_gate_low_a: assert property ($rose(reference_clock_out_oe_n)
    |-> !$past(reference_clock_out))
    else $error("reference floated while high");
  main_gate_low_a: assert property ($rose(main_clock_out_oe_n)
    |-> !$past(main_clock_out))
    else $error("main floated while high");
  main_enable_low_a: assert property (
    $fell(main_clock_out_oe_n) |-> !main_clock_out)
    else $error("main enabled in high phase");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property ($past(reg_rd) &&
    $past(reg_addr) > 4'h2 |-> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  mux_reserved_a: assert property ($past(reg_rd) &&
    $past(reg_addr) == docd_pkg::REG_MUX |->
    (reg_rdata & ~docd_pkg::MUX_MASK) == 16'h0)
    else $error("mode word reserved bits set");
  div_reserved_a: assert property ($past(reg_rd) &&
    $past(reg_addr) == docd_pkg::REG_DIV |-> reg_rdata[15:10] == 6'h0)
    else $error("divider word reserved bits set");
endmodule // docd_top_asserts

bind docd_top docd_top_asserts #(.STARTUP_CLKS(STARTUP_CLKS)) chk_u (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reference_clock_out(reference_clock_out),
  .reference_clock_out_oe_n(reference_clock_out_oe_n),
  .main_clock_out(main_clock_out),
  .main_clock_out_oe_n(main_clock_out_oe_n)
);

// >>> docd_top_tb_top.sv
// self-checking bench for the dual output clock divider
`timescale 1ns/10ps
module docd_top_tb_top;
  // ******************************
  // harness
  // ******************************
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, dv;
  logic        clk, reset, reg_wr, reg_rd, rd_seen, pin_a, pin_b;
  logic        ref_o, ref_oe_n, main_o, main_oe_n;
  int          mismatches, tests_run, seed;
  logic [15:0] mv[4] = '{16'h1, 16'h7, 16'h2, 16'h4};
  logic [15:0] nv[4] = '{16'h3, 16'h3, 16'h0, 16'h3};
  int          mh[4] = '{1, 8, 4, 20};

  docd_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  // short startup count keeps the run brief
  docd_top #(.STARTUP_CLKS(20)) dut_u (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .control_pin_a(pin_a),
    .control_pin_b(pin_b), .reference_clock_out(ref_o),
    .reference_clock_out_oe_n(ref_oe_n), .main_clock_out(main_o),
    .main_clock_out_oe_n(main_oe_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (rd_seen === 1'b1) begin
      chk("reg_rdata", reg_rdata, host_u.exp_q.pop_front());
    end
    rd_seen <= reg_rd;
  end

  function automatic logic sig(input logic w);
    return w ? main_o : ref_o;
  endfunction

  // bounded wait for a wave level; a hang ends the run
  task automatic wt(input logic w, input logic l);
    int i;
    for (i = 0; i < 400 && sig(w) !== l; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 400) begin
      mismatches++;
      finish_test();
    end
  endtask

  // skips one whole period so a pending setting has landed
  task automatic meas(input logic w, input int e);
    int c;
    c = 0;
    wt(w, 1'b0);
    wt(w, 1'b1);
    wt(w, 1'b0);
    wt(w, 1'b1);
    while (sig(w) === 1'b1 && c < 400) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk(w ? "main_half" : "ref_half", 16'(c), 16'(e));
  endtask

  task automatic pins(input logic a, input logic b, input int n);
    @(posedge clk);
    pin_a <= a;
    pin_b <= b;
    repeat (n) @(posedge clk);
  endtask

  // ******************************
  // scenarios
  // ******************************
  initial begin
    seed = 54765;
    reset = 1'b1;
    pin_a = 1'b0;
    pin_b = 1'b0;
    rd_seen = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    chk("oe_n", {14'h0, ref_oe_n, main_oe_n}, 16'h3);
    meas(1'b0, 1);
    meas(1'b1, 2);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      host_u.wr(docd_pkg::REG_DIV, nv[i]);
      host_u.wr(docd_pkg::REG_MUX, 16'h00c0 | 16'(i << 3) | mv[i]);
      meas(1'b0, 1 << i);
      meas(1'b1, mh[i]);
    end
    $display("test dividers done");
    host_u.wr(docd_pkg::REG_MUX, 16'h0058);
    meas(1'b0, 1);
    pins(1'b1, 1'b0, 0);
    host_u.wr(docd_pkg::REG_MUX, 16'h0058);
    meas(1'b0, 8);
    host_u.wr(docd_pkg::REG_MUX, 16'h0020);
    repeat (40) @(posedge clk);
    chk("ref_oe_n", {15'h0, ref_oe_n}, 16'h1);
    pins(1'b0, 1'b0, 0);
    meas(1'b0, 1);
    $display("test pin a done");
    host_u.wr(docd_pkg::REG_MUX, 16'h01c0);
    pins(1'b0, 1'b1, 40);
    chk("oe_n", {14'h0, ref_oe_n, main_oe_n}, 16'h3);
    host_u.rd(docd_pkg::REG_STAT, 16'h0002);
    host_u.wr(docd_pkg::REG_DIV, 16'h0155);
    pins(1'b0, 1'b0, 60);
    host_u.rd(docd_pkg::REG_DIV, 16'h0003);
    host_u.rd(docd_pkg::REG_STAT, 16'h000d);
    $display("test power-down done");
    host_u.wr(docd_pkg::REG_MUX, 16'h0000);
    pins(1'b1, 1'b0, 40);
    host_u.rd(docd_pkg::REG_STAT, 16'h0002);
    pins(1'b0, 1'b0, 60);
    host_u.rd(docd_pkg::REG_STAT, 16'h0009);
    $display("test shutdown done");
    host_u.wr(docd_pkg::REG_MUX, 16'h00c0);
    pins(1'b0, 1'b1, 0);
    pins(1'b0, 1'b0, 10);
    chk("main_oe_n", {15'h0, main_oe_n}, 16'h0);
    pins(1'b0, 1'b1, 40);
    chk("main_oe_n", {15'h0, main_oe_n}, 16'h1);
    pins(1'b0, 1'b0, 40);
    $display("test pin b done");
    host_u.wr(4'hf, 16'hffff);
    host_u.rd(4'hf, 16'h0000);
    host_u.wr(docd_pkg::REG_STAT, 16'hffff);
    host_u.rd(docd_pkg::REG_STAT, 16'h000d);
    rv = 16'($random(seed));
    dv = 16'($random(seed));
    host_u.wr(docd_pkg::REG_MUX, rv);
    host_u.wr(docd_pkg::REG_DIV, dv);
    host_u.rd(docd_pkg::REG_MUX, rv & docd_pkg::MUX_MASK);
    host_u.rd(docd_pkg::REG_DIV, dv & docd_pkg::DIV_MASK);
    $display("test registers done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    host_u.rd(docd_pkg::REG_MUX, rv & docd_pkg::MUX_MASK);
    host_u.rd(docd_pkg::REG_DIV, dv & docd_pkg::DIV_MASK);
    repeat (3) @(posedge clk);
    $display("test retention done");
    finish_test();
  end
endmodule // docd_top_tb_top
